// >>> src/fprf_pkg.sv
/*
 * Constants shared by the floating point register file block.
 * Assumes nothing of its surroundings; imported by the design modules.
 */
// What this block does
// - Three 11-bit pointers A, B, destination, each loadable from the bus.
// - Each pointer increments at cycle end when its enable is set.
// - Storage is 2K entries of 32 bits, selected by the pointer.
// - Half select 0 picks the high half, 1 picks the low half.
// - Pointer A addresses bus read data and the A operand.
// - Pointer B addresses the B operand.
// - Destination pointer addresses every write, result or bus word.
// - Two banks read by A and B; every write updates both.
// - Bus reads come from bank A unless the diagnostic flag picks B.
// - Bus writes go to a holding buffer, committed next cycle.
// - Destination increment with a bus write happens next cycle too.
// - Read in the first half cycle, write in the second.
// - A op B or result op B, exclusive; store may join either.
// - Half select drives the address low bit and the unload select.
package fprf_pkg;
    localparam int PTR_W = 11;
    localparam int HALF_W = 16;
    localparam int ENTRIES = 2048;
    localparam logic [10:0] PTR_RESET = 11'h000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic HALF_HIGH = 1'b0;
    localparam int OP_SPACING = 2;
    // Operand source selection seen by the floating point unit.
    typedef enum logic [1:0] {
        FPRF_OP_NONE,
        FPRF_OP_AB,
        FPRF_OP_RB
    } fprf_op_t;
endpackage

// >>> src/fprf_bank.sv
/*
 * One bank of the floating point register file: 16-bit words, registered read.
 * Assumes a single clock; write and read ports are independent.
 */
`timescale 1ns/1ns
`default_nettype none
module fprf_bank
    import fprf_pkg::*;
#(
    parameter int AW = 12
) (
    // Clock.
    input wire logic clk,
    // Read port.
    input wire logic [AW-1:0] readAddr,
    output logic [15:0] readData,
    // Write port.
    input wire logic writeEn,
    input wire logic [AW-1:0] writeAddr,
    input wire logic [15:0] writeData
);
    // Refuse an address range that could hold no word at all.
    if (AW < 1) begin : gen_bad_aw
        $error("fprf_bank needs at least one address bit");
    end

    logic [15:0] mem [0:(1<<AW)-1];

    // Registered read and write of the array.
    always_ff @(posedge clk) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
        readData <= mem[readAddr];
    end
endmodule
`default_nettype wire

// >>> src/fprf_top.sv
/*
 * Floating point register file with source A, source B and destination
 * pointers. One clk cycle is one processor cycle. Reads are issued at the
 * cycle start and return registered at the next edge (first half), writes
 * commit at the edge closing the cycle (second half).
 * Assumes the sequencer drives control inputs on clk and obeys the
 * operation spacing and bus-then-result ordering.
 */
`timescale 1ns/1ns
`default_nettype none
module fprf_top
    import fprf_pkg::*;
#(
    parameter int PW = PTR_W
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Microinstruction fields.
    input wire logic halfSel,
    input wire logic loadPtrA,
    input wire logic loadPtrB,
    input wire logic loadPtrD,
    input wire logic incPtrA,
    input wire logic incPtrB,
    input wire logic incPtrD,
    input wire logic busSrcFp,
    input wire logic busDstFp,
    input wire logic [1:0] fpOp,
    input wire logic storeResult,
    // Status register diagnostic flag.
    input wire logic diagSelB,
    // Internal processor bus.
    input wire logic [15:0] proc_internal_bus_in,
    output logic [15:0] proc_internal_bus_out,
    output logic proc_internal_bus_oe,
    // Floating point unit side.
    output logic [15:0] operandA,
    output logic [15:0] operandB,
    output logic [1:0] fpuOp,
    output logic unloadHalf,
    input wire logic [15:0] fpResult,
    // Pointer state.
    output logic [PW-1:0] ptrA,
    output logic [PW-1:0] ptrB,
    output logic [PW-1:0] ptrD
);
    // Refuse pointer widths other than the one the array is built for.
    if (PW != PTR_W) begin : gen_bad_width
        $error("fprf_top supports only 11-bit pointers");
    end

    logic holdValid;
    logic holdInc;
    logic [15:0] holdData;
    logic [PW:0] holdAddr;
    logic [15:0] bankAData;
    logic [15:0] bankBData;
    logic wrEn;
    logic [PW:0] wrAddr;
    logic [15:0] wrData;
    logic readSrcB;
    logic busRead;
    logic [1:0] opQ;

    // Every check below samples on clk and rests while reset is held.
    default clocking checkClk @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Pointer A: bus load, else wrapping increment.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ptrA <= PTR_RESET;
        end else if (loadPtrA) begin
            ptrA <= proc_internal_bus_in[PW-1:0];
        end else if (incPtrA) begin
            ptrA <= ptrA + 1'b1;
        end
    end

    // Pointer B: bus load, else wrapping increment.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ptrB <= PTR_RESET;
        end else if (loadPtrB) begin
            ptrB <= proc_internal_bus_in[PW-1:0];
        end else if (incPtrB) begin
            ptrB <= ptrB + 1'b1;
        end
    end

    // Destination pointer; a count tied to a bus write is deferred.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ptrD <= PTR_RESET;
        end else if (loadPtrD) begin
            ptrD <= proc_internal_bus_in[PW-1:0];
        end else if (holdInc || (incPtrD && !busDstFp)) begin
            ptrD <= ptrD + 1'b1;
        end
    end

    // Holding buffer for bus words headed to the array.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            holdValid <= 1'b0;
            holdInc <= 1'b0;
            holdData <= DATA_RESET;
            holdAddr <= '0;
        end else begin
            holdValid <= busDstFp;
            holdInc <= busDstFp && incPtrD;
            holdData <= proc_internal_bus_in;
            holdAddr <= {ptrD, halfSel};
        end
    end

    // Write selection: held bus word, else the unit's result.
    always_comb begin
        wrEn = holdValid || storeResult;
        wrAddr = holdValid ? holdAddr : {ptrD, halfSel};
        wrData = holdValid ? holdData : fpResult;
    end

    // Both banks receive each write so they stay duplicates.
    fprf_bank #(.AW(PW + 1)) bankA (
        .clk(clk),
        .readAddr({ptrA, halfSel}),
        .readData(bankAData),
        .writeEn(wrEn),
        .writeAddr(wrAddr),
        .writeData(wrData)
    );
    fprf_bank #(.AW(PW + 1)) bankB (
        .clk(clk),
        .readAddr({ptrB, halfSel}),
        .readData(bankBData),
        .writeEn(wrEn),
        .writeAddr(wrAddr),
        .writeData(wrData)
    );

    // Registers qualifying the read results.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readSrcB <= 1'b0;
            busRead <= 1'b0;
            opQ <= 2'h0;
        end else begin
            readSrcB <= diagSelB;
            busRead <= busSrcFp;
            opQ <= (fpOp == 2'h3) ? 2'h0 : fpOp;
        end
    end

    // Bus and operand outputs.
    always_comb begin
        proc_internal_bus_out = readSrcB ? bankBData : bankAData;
        proc_internal_bus_oe = busRead;
        operandA = bankAData;
        operandB = bankBData;
        fpuOp = opQ;
        unloadHalf = halfSel;
    end

    // Pointer checks: loads, counts and the wrap at the top of the range.
    ptrWrap_a: assert property (
        (!loadPtrA && incPtrA && ptrA == 11'h7ff) |=> ptrA == 11'h000)
        else $error("pointer A did not wrap");
    ptrAInc_a: assert property ((!loadPtrA && incPtrA) |=>
        ptrA == $past(ptrA) + 11'h001)
        else $error("pointer A did not count");
    ptrBInc_a: assert property ((!loadPtrB && incPtrB) |=>
        ptrB == $past(ptrB) + 11'h001)
        else $error("pointer B did not count");
    ptrLoad_a: assert property (loadPtrB |=>
        ptrB == $past(proc_internal_bus_in[10:0]))
        else $error("pointer B load lost");
    ptrDLoad_a: assert property (loadPtrD |=>
        ptrD == $past(proc_internal_bus_in[10:0]))
        else $error("destination pointer load lost");

    // A plain count of the destination pointer takes effect at once.
    ptrDInc_a: assert property (
        (incPtrD && !busDstFp && !loadPtrD && !holdInc) |=>
        ptrD == $past(ptrD) + 11'h001)
        else $error("destination pointer did not count");
    // A count that rides with a bus write lands one cycle late.
    deferInc_a: assert property (
        (busDstFp && incPtrD && !loadPtrD && !holdInc) ##1 !loadPtrD
        |=> ptrD == $past(ptrD, 2) + 11'h001)
        else $error("deferred destination count wrong");

    // Datapath checks: the held bus word, the bus source and the banks.
    holdCommit_a: assert property (
        busDstFp |=> wrEn && wrData == $past(proc_internal_bus_in))
        else $error("bus word not committed next cycle");
    busSource_a: assert property ((busSrcFp && !diagSelB) |=>
        proc_internal_bus_oe && proc_internal_bus_out == bankAData)
        else $error("bus read not from bank A");
    diagRoute_a: assert property ((busSrcFp && diagSelB) |=>
        proc_internal_bus_oe && proc_internal_bus_out == bankBData)
        else $error("diagnostic read not from bank B");
    busIdle_a: assert property (!busSrcFp |=> !proc_internal_bus_oe)
        else $error("bus driven without a read");
    banksEqual_a: assert property (wrEn |=>
        bankA.mem[$past(wrAddr)] == $past(wrData)
        && bankB.mem[$past(wrAddr)] == $past(wrData))
        else $error("banks diverged");
    resultWrite_a: assert property (
        (storeResult && !holdValid) |=>
        bankA.mem[{$past(ptrD), $past(halfSel)}] == $past(fpResult))
        else $error("result written to wrong entry");
    halfSel_a: assert property (unloadHalf == halfSel)
        else $error("unload half select mismatch");

    // Operation field: the illegal code is dropped, the rest pass on.
    opExcl_a: assert property (fpOp == 2'h3 |=> fpuOp == 2'h0)
        else $error("illegal operation passed on");
    opPass_a: assert property (fpOp != 2'h3 |=> fpuOp == $past(fpOp))
        else $error("operation not passed on");

    // Cover points for the main scenarios.
    busWrite_c: cover property (busDstFp && incPtrD);
    diagRead_c: cover property (busSrcFp && diagSelB);
    opStore_c: cover property (fpOp == 2'h1 && storeResult);
    resultStore_c: cover property (storeResult && incPtrD);
    wrapA_c: cover property (incPtrA && ptrA == 11'h7ff);
endmodule
`default_nettype wire

// >>> tb/fprf_fpu_model.sv
/* Behavioural model of the pipelined floating point unit.
   Assumes operands and op arrive registered from the register file. */
`timescale 1ns/1ns
`default_nettype none
module fprf_fpu_model
    import fprf_pkg::*;
#(
    parameter int LAT = 12
) (
    // Clock.
    input wire logic clk,
    // Operation and operands from the register file.
    input wire logic [1:0] fpuOp,
    input wire logic [15:0] operandA,
    input wire logic [15:0] operandB,
    // Result half back to the register file.
    output logic [15:0] fpResult
);
    logic [15:0] res = 16'h0000;
    int cnt = 0;
    // Starts an operation and counts down the pipeline delay.
    always @(posedge clk) begin
        if (fpuOp == FPRF_OP_AB) begin
            res <= operandA ^ operandB;
            cnt <= LAT;
        end else if (fpuOp == FPRF_OP_RB) begin
            res <= res ^ operandB;
            cnt <= LAT;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // An unfinished result shows inverted, so an early store is caught.
    assign fpResult = (cnt == 0) ? res : ~res;
endmodule
`default_nettype wire

// >>> tb/test_fprf_top.sv
/* Self-checking bench for the floating point register file.
   Assumes the unit model in fprf_fpu_model.sv supplies results. */
`timescale 1ns/1ns
`default_nettype none
module test_fprf_top;
    localparam int LAT = 12;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic halfSel, loadPtrA, loadPtrB, loadPtrD, incPtrA, incPtrB, incPtrD;
    logic busSrcFp, busDstFp, storeResult, diagSelB, busOe, unloadHalf, h;
    logic [1:0] fpOp, fpuOp;
    logic [15:0] busIn, busOut, operandA, operandB, fpResult, r;
    logic [10:0] ptrA, ptrB, ptrD, pA, pB, pD, base;
    logic [15:0] mem [4096];
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    fprf_top uut (.clk(clk), .reset_n(reset_n), .halfSel(halfSel),
        .loadPtrA(loadPtrA), .loadPtrB(loadPtrB), .loadPtrD(loadPtrD),
        .incPtrA(incPtrA), .incPtrB(incPtrB), .incPtrD(incPtrD),
        .busSrcFp(busSrcFp), .busDstFp(busDstFp), .fpOp(fpOp),
        .storeResult(storeResult), .diagSelB(diagSelB),
        .proc_internal_bus_in(busIn), .proc_internal_bus_out(busOut),
        .proc_internal_bus_oe(busOe), .operandA(operandA),
        .operandB(operandB), .fpuOp(fpuOp), .unloadHalf(unloadHalf),
        .fpResult(fpResult), .ptrA(ptrA), .ptrB(ptrB), .ptrD(ptrD));
    fprf_fpu_model #(.LAT(LAT)) fpu (.clk(clk), .fpuOp(fpuOp),
        .operandA(operandA), .operandB(operandB), .fpResult(fpResult));

    // Free running clock, cut short if the run hangs.
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chkData(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t data %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkCtl(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ctl %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkPtrs();
        checks++;
        if ({ptrA, ptrB, ptrD} !== {pA, pB, pD}) begin
            miscompares++;
            $display("[FAIL] %0t ptr %h exp %h", $time, {ptrA, ptrB, ptrD},
                {pA, pB, pD});
        end
    endtask
    task automatic idle();
        {loadPtrA, loadPtrB, loadPtrD, incPtrA, incPtrB, incPtrD} = '0;
        {busSrcFp, busDstFp, storeResult, fpOp} = '0;
    endtask
    task automatic ldPtr(input int w, input logic [10:0] v);
        busIn = {5'h00, v};
        {loadPtrA, loadPtrB, loadPtrD} = {w == 0, w == 1, w == 2};
        @(negedge clk);
        idle();
        pA = (w == 0) ? v : pA;
        pB = (w == 1) ? v : pB;
        pD = (w == 2) ? v : pD;
        chkPtrs();
        @(negedge clk);
    endtask
    task automatic busWr(input logic [15:0] d);
        {busDstFp, incPtrD, halfSel} = {2'h3, h};
        busIn = d;
        @(negedge clk);
        idle();
        busIn = 16'($urandom);
        chkPtrs();
        mem[{pD, h}] = d;
        pD = pD + 11'h1;
        @(negedge clk);
        chkPtrs();
    endtask
    task automatic busRd(input logic hh, input logic diag);
        {busSrcFp, halfSel, diagSelB} = {1'b1, hh, diag};
        @(negedge clk);
        idle();
        chkData(busOut, mem[{diag ? pB : pA, hh}]);
        chkCtl({1'b0, busOe}, 2'h1);
        @(negedge clk);
        chkCtl({1'b0, busOe}, 2'h0);
    endtask
    task automatic opRun(input logic [1:0] op);
        fpOp = op;
        @(negedge clk);
        idle();
        chkCtl(fpuOp, (op == 2'h3) ? 2'h0 : op);
        chkCtl({1'b0, unloadHalf}, {1'b0, h});
        chkData(operandA, mem[{pA, h}]);
        chkData(operandB, mem[{pB, h}]);
        r = (op == 2'h1) ? mem[{pA, h}] ^ mem[{pB, h}] : r;
        r = (op == 2'h2) ? r ^ mem[{pB, h}] : r;
        @(negedge clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence: wrap, then random bus, operand and result traffic.
    initial begin
        void'($urandom(82925));
        idle();
        {halfSel, diagSelB, busIn, r, h, pA, pB, pD} = '0;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        chkPtrs();
        for (int w = 0; w < 3; w++) ldPtr(w, 11'h7ff);
        {incPtrA, incPtrB, incPtrD} = 3'h7;
        @(negedge clk);
        idle();
        {pA, pB, pD} = '0;
        chkPtrs();
        for (int i = 0; i < 20; i++) begin
            base = (i == 0) ? 11'h7fe : 11'($urandom);
            for (int k = 0; k < 2; k++) begin
                h = k[0];
                ldPtr(2, base);
                repeat (2) busWr(16'($urandom));
            end
            ldPtr(0, base);
            ldPtr(1, base + 11'h1);
            for (int k = 0; k < 4; k++) busRd(k[0], k[1]);
            h = 1'($urandom);
            halfSel = h;
            for (int op = 0; op < 4; op++) opRun(2'(op));
            repeat (LAT + 2) @(negedge clk);
            {storeResult, incPtrD} = 2'h3;
            @(negedge clk);
            idle();
            mem[{pD, h}] = r;
            pD = pD + 11'h1;
            chkPtrs();
            @(negedge clk);
            ldPtr(0, pD - 11'h1);
            busRd(h, 1'b0);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
